// *** inc/lcsc_pkg.sv ***
/*
 * lcsc_pkg: register map, field positions, reset values and fixed figures
 * of the LCD system configuration block.
 * Assumes one clock and a byte-wide register port whose writes come as
 * one-cycle strobes.
 */
// Notes on behaviour
// - character height bit 0 gives 8-pixel bitmaps, 1 gives 16-pixel bitmaps.
// - generator select 0 picks the fixed character ROM, 1 the user RAM.
// - the fixed ROM holds 160 unchangeable characters of 5x7 pixels.
// - user RAM holds 256 characters, only 64 of 8x8 when ROM selected.
// - while user RAM is in use only one bit per pixel is supported.
// - origin compensation shifts fonts down a row; software may raise screen lines.
// - AC drive select 0 gives 16-line drive, 1 gives two-frame drive.
// - two-frame drive has twice the frame period; 16-line inverts every 16 lines.
// - horizontal size field holds character width in pixels minus one.
// - data moves in bytes; wide characters use 8-pixel segments, remainder hidden.
// - vertical size field holds character height in pixels minus one.
// - total row byte count holds the whole line length in bytes minus one, at most 256 bytes.
// - frame line count holds lines per frame minus one, at most 256 lines.
// - a 15-bit line address range from two bytes, at most 7FFFh.
// - power save bit 1 stops everything, 0 resumes; it resets to 1.
// - entering power save clears display enable; software sets it again.
// - indirectly, power save command enters and system configuration exits.
// - writing memory configuration resets timing, blanks display, exits power save in indirect mode.
// - panel drive select 0 gives single panel, 1 gives dual panel.
// - origin compensation bit 0 enables compensation, 1 disables it.
package lcsc_pkg;
    // register byte addresses
    localparam logic [15:0] ADDR_MEM_CFG    = 16'h8000;
    localparam logic [15:0] ADDR_HSIZE      = 16'h8001;
    localparam logic [15:0] ADDR_VSIZE      = 16'h8002;
    localparam logic [15:0] ADDR_ROW_BYTES  = 16'h8003;
    localparam logic [15:0] ADDR_TOTAL_ROW  = 16'h8004;
    localparam logic [15:0] ADDR_FRAME      = 16'h8005;
    localparam logic [15:0] ADDR_RANGE_LO   = 16'h8006;
    localparam logic [15:0] ADDR_RANGE_HI   = 16'h8007;
    localparam logic [15:0] ADDR_POWER      = 16'h8008;
    localparam logic [15:0] ADDR_DISP_EN    = 16'h8009;
    // reset values
    localparam logic [7:0]  RST_MEM_CFG     = 8'h10;
    localparam logic [7:0]  RST_ZERO        = 8'h00;
    localparam logic [7:0]  RST_POWER       = 8'h01;
    // writable bit masks, the rest read as zero
    localparam logic [7:0]  MASK_MEM_CFG    = 8'h3F;
    localparam logic [7:0]  MASK_HSIZE      = 8'h8F;
    localparam logic [7:0]  MASK_VSIZE      = 8'h0F;
    localparam logic [7:0]  MASK_BIT0       = 8'h01;
    // field positions
    localparam int          MC_GEN_SEL      = 0;
    localparam int          MC_CHAR_H       = 2;
    localparam int          MC_DUAL         = 3;
    localparam int          MC_ORIGIN       = 5;
    localparam int          HS_AC_SEL       = 7;
    localparam int          PS_BIT          = 0;
    // character and memory figures
    localparam logic [4:0]  CHAR_H_SHORT    = 5'd8;
    localparam logic [4:0]  CHAR_H_TALL     = 5'd16;
    localparam logic [7:0]  ROM_CHARS       = 8'd160;
    localparam logic [2:0]  ROM_GLYPH_W     = 3'd5;
    localparam logic [2:0]  ROM_GLYPH_H     = 3'd7;
    localparam logic [8:0]  RAM_CHARS_FULL  = 9'd256;
    localparam logic [8:0]  RAM_CHARS_SHARE = 9'd64;
    localparam logic [14:0] RANGE_MAX       = 15'h7FFF;
    localparam logic [3:0]  AC_LINES_LAST   = 4'hF;
endpackage

// *** verilog/lcsc_wrap_counter.sv ***
/*
 * lcsc_wrap_counter: up counter that wraps to zero after reaching a limit.
 * Assumes clr and run are synchronous to clk; ce freezes it.
 */
`timescale 1ns/1ps
`default_nettype none
module lcsc_wrap_counter #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         ce,
    // control
    input  wire logic         clr,
    input  wire logic         run,
    input  wire logic [W-1:0] limit,
    // state
    output logic      [W-1:0] count,
    output logic              wrap
);
    // combinational so the next stage steps in the same cycle
    assign wrap = run && (count == limit);

    // count up, wrap at limit; clear takes priority
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else if (ce) begin
            if (clr) begin
                count <= '0;
            end else if (wrap) begin
                count <= '0;
            end else if (run) begin
                count <= count + 1'b1;
            end
        end
    end
endmodule // lcsc_wrap_counter
`default_nettype wire

// *** verilog/lcsc_sys_config.sv ***
/*
 * lcsc_sys_config: system configuration registers of a graphics LCD
 * controller with the display timing generator they steer.
 * Assumes a synchronous byte register port, a mode input telling direct
 * from indirect addressing, and a one-cycle power save command strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module lcsc_sys_config (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // register port
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // addressing mode and commands
    input  wire logic        indirect_mode,
    input  wire logic        cmd_power_save,
    // character generation
    output logic      [4:0]  char_height_px,
    output logic             char_generator_select,
    output logic      [8:0]  user_char_capacity,
    output logic             one_bpp_only,
    output logic             font_row_shift,
    output logic             dual_panel,
    output logic      [3:0]  char_width_field,
    output logic      [3:0]  char_height_field,
    output logic      [4:0]  char_segments,
    output logic      [7:0]  last_segment_mask,
    output logic      [14:0] line_address_range,
    // timing and power
    output logic             h_active,
    output logic             line_start,
    output logic             frame_start,
    output logic             ac_drive,
    output logic             display_on,
    output logic             osc_stopped
);
    import lcsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // register storage
    logic [7:0] memory_configuration_r;
    logic [7:0] horizontal_char_size_r;
    logic [7:0] vertical_char_size_r;
    logic [7:0] row_byte_count_r;
    logic [7:0] total_row_byte_count_r;
    logic [7:0] frame_line_count_r;
    logic [7:0] line_address_range_low_r;
    logic [7:0] line_address_range_high_r;
    logic       power_save_r;
    logic       wake_pending_r;
    logic       display_enable_r;

    // write decode
    logic wr_mc;
    logic wr_ps;
    logic wr_de;
    logic ps_nxt;
    logic enter_ps;
    assign wr_mc = reg_wr && (reg_addr == ADDR_MEM_CFG);
    assign wr_ps = reg_wr && (reg_addr == ADDR_POWER);
    assign wr_de = reg_wr && (reg_addr == ADDR_DISP_EN);

    // configuration fields keep written values until rewritten
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            memory_configuration_r    <= RST_MEM_CFG;
            horizontal_char_size_r    <= RST_ZERO;
            vertical_char_size_r      <= RST_ZERO;
            row_byte_count_r          <= RST_ZERO;
            total_row_byte_count_r    <= RST_ZERO;
            frame_line_count_r        <= RST_ZERO;
            line_address_range_low_r  <= RST_ZERO;
            line_address_range_high_r <= RST_ZERO;
        end else if (ce && reg_wr) begin
            unique case (reg_addr)
                ADDR_MEM_CFG:   memory_configuration_r    <= reg_wdata & MASK_MEM_CFG;
                ADDR_HSIZE:     horizontal_char_size_r    <= reg_wdata & MASK_HSIZE;
                ADDR_VSIZE:     vertical_char_size_r      <= reg_wdata & MASK_VSIZE;
                ADDR_ROW_BYTES: row_byte_count_r          <= reg_wdata;
                ADDR_TOTAL_ROW: total_row_byte_count_r    <= reg_wdata;
                ADDR_FRAME:     frame_line_count_r        <= reg_wdata;
                ADDR_RANGE_LO:  line_address_range_low_r  <= reg_wdata;
                ADDR_RANGE_HI:  line_address_range_high_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power save: asleep until the exit is complete
    always_comb begin
        ps_nxt = power_save_r;
        if (wr_ps) begin
            ps_nxt = reg_wdata[PS_BIT];
        end else if (indirect_mode && cmd_power_save) begin
            ps_nxt = 1'b1;
        end else if (indirect_mode && wr_mc) begin
            ps_nxt = 1'b0;
        end
    end
    assign enter_ps = ps_nxt && !power_save_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            power_save_r <= RST_POWER[PS_BIT];
        end else if (ce) begin
            power_save_r <= ps_nxt;
        end
    end

    // direct mode needs one more write of any register to wake fully
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wake_pending_r <= 1'b0;
        end else if (ce) begin
            if (ps_nxt) begin
                wake_pending_r <= 1'b0;
            end else if (wr_ps && power_save_r && !indirect_mode) begin
                wake_pending_r <= 1'b1;
            end else if (reg_wr) begin
                wake_pending_r <= 1'b0;
            end
        end
    end

    // hardware blanking wins over a software set in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            display_enable_r <= 1'b0;
        end else if (ce) begin
            if (enter_ps || wr_mc) begin
                display_enable_r <= 1'b0;
            end else if (wr_de) begin
                display_enable_r <= reg_wdata[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timing generator, frozen while asleep
    logic       asleep;
    logic       tg_run;
    logic [7:0] byte_cnt;
    logic       byte_wrap;
    logic [7:0] line_cnt;
    logic       line_wrap;
    logic [3:0] ac_line_cnt_r;
    assign asleep = power_save_r || wake_pending_r;
    assign tg_run = !asleep;

    // one byte per clock across the whole line including blanking
    lcsc_wrap_counter #(.W(8)) u_byte_cnt (
        .clk   (clk),
        .rstn  (rstn),
        .ce    (ce),
        .clr   (wr_mc),
        .run   (tg_run),
        .limit (total_row_byte_count_r),
        .count (byte_cnt),
        .wrap  (byte_wrap)
    );

    // lines step at each line end, the frame ends after the last line
    lcsc_wrap_counter #(.W(8)) u_line_cnt (
        .clk   (clk),
        .rstn  (rstn),
        .ce    (ce),
        .clr   (wr_mc),
        .run   (byte_wrap),
        .limit (frame_line_count_r),
        .count (line_cnt),
        .wrap  (line_wrap)
    );

    // sixteen-line group counter for line based AC drive
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ac_line_cnt_r <= 4'h0;
        end else if (ce) begin
            if (wr_mc) begin
                ac_line_cnt_r <= 4'h0;
            end else if (byte_wrap) begin
                ac_line_cnt_r <= ac_line_cnt_r + 4'h1;
            end
        end
    end

    // AC drive waveform; two-frame mode toggles once per frame
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ac_drive <= 1'b0;
        end else if (ce) begin
            if (wr_mc) begin
                ac_drive <= 1'b0;
            end else if (horizontal_char_size_r[HS_AC_SEL]) begin
                if (line_wrap) begin
                    ac_drive <= !ac_drive;
                end
            end else if (byte_wrap && ac_line_cnt_r == AC_LINES_LAST) begin
                ac_drive <= !ac_drive;
            end
        end
    end

    // line and frame marks plus visible span
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            h_active    <= 1'b0;
            line_start  <= 1'b0;
            frame_start <= 1'b0;
            display_on  <= 1'b0;
            osc_stopped <= 1'b1;
        end else if (ce) begin
            h_active    <= tg_run && (byte_cnt <= row_byte_count_r);
            line_start  <= byte_wrap;
            frame_start <= line_wrap;
            display_on  <= display_enable_r && tg_run;
            osc_stopped <= asleep;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decoded character geometry
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            char_height_px        <= CHAR_H_SHORT;
            char_generator_select <= 1'b0;
            user_char_capacity    <= RAM_CHARS_SHARE;
            one_bpp_only          <= 1'b0;
            font_row_shift        <= 1'b0;
            dual_panel            <= 1'b0;
            char_width_field      <= 4'h0;
            char_height_field     <= 4'h0;
            char_segments         <= 5'h01;
            last_segment_mask     <= 8'h80;
            line_address_range    <= 15'h0000;
        end else if (ce) begin
            char_height_px <= memory_configuration_r[MC_CHAR_H]
                              ? CHAR_H_TALL : CHAR_H_SHORT;
            // the fixed glyph ROM has no write path, so its set cannot change
            char_generator_select <= memory_configuration_r[MC_GEN_SEL];
            user_char_capacity <= memory_configuration_r[MC_GEN_SEL]
                                  ? RAM_CHARS_FULL : RAM_CHARS_SHARE;
            one_bpp_only   <= memory_configuration_r[MC_GEN_SEL];
            font_row_shift <= !memory_configuration_r[MC_ORIGIN];
            dual_panel     <= memory_configuration_r[MC_DUAL];
            char_width_field  <= horizontal_char_size_r[3:0];
            char_height_field <= vertical_char_size_r[3:0];
            char_segments <= {4'h0, horizontal_char_size_r[3]} + 5'h01;
            // pixels beyond the width in the last byte stay dark
            last_segment_mask <= 8'hFF << (3'd7 - horizontal_char_size_r[2:0]);
            // clamped so the scan never exceeds the largest legal range
            line_address_range <= line_address_range_high_r[7]
                ? RANGE_MAX
                : {line_address_range_high_r[6:0], line_address_range_low_r};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read side, answered one cycle after the strobe
    logic [7:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            ADDR_MEM_CFG:   rd_mux = memory_configuration_r;
            ADDR_HSIZE:     rd_mux = horizontal_char_size_r;
            ADDR_VSIZE:     rd_mux = vertical_char_size_r;
            ADDR_ROW_BYTES: rd_mux = row_byte_count_r;
            ADDR_TOTAL_ROW: rd_mux = total_row_byte_count_r;
            ADDR_FRAME:     rd_mux = frame_line_count_r;
            ADDR_RANGE_LO:  rd_mux = line_address_range_low_r;
            ADDR_RANGE_HI:  rd_mux = line_address_range_high_r;
            ADDR_POWER:     rd_mux = {7'h00, power_save_r};
            ADDR_DISP_EN:   rd_mux = {7'h00, display_enable_r};
            default:        rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (ce && reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_char_height;
        @(posedge clk) disable iff (!rstn)
        (ce && memory_configuration_r[MC_CHAR_H]) |=> (char_height_px == CHAR_H_TALL);
    endproperty
    a_char_height: assert property (p_char_height) else $error("char height not 16");

    property p_ram_bpp;
        @(posedge clk) disable iff (!rstn)
        (ce && memory_configuration_r[MC_GEN_SEL])
            |=> (one_bpp_only && user_char_capacity == RAM_CHARS_FULL);
    endproperty
    a_ram_bpp: assert property (p_ram_bpp) else $error("user RAM not limited to 1 bpp");

    property p_two_frame;
        @(posedge clk) disable iff (!rstn)
        (ce && !wr_mc && horizontal_char_size_r[HS_AC_SEL] && line_wrap)
            |=> (ac_drive != $past(ac_drive));
    endproperty
    a_two_frame: assert property (p_two_frame) else $error("AC drive missed frame toggle");

    property p_sixteen_line;
        @(posedge clk) disable iff (!rstn)
        (ce && !wr_mc && !horizontal_char_size_r[HS_AC_SEL] && byte_wrap
            && ac_line_cnt_r != AC_LINES_LAST) |=> $stable(ac_drive);
    endproperty
    a_sixteen_line: assert property (p_sixteen_line) else $error("AC drive early toggle");

    property p_ps_enter;
        @(posedge clk) disable iff (!rstn)
        (ce && wr_ps && reg_wdata[PS_BIT]) |=> (power_save_r && !display_enable_r)
            ##1 (!ce || osc_stopped);
    endproperty
    a_ps_enter: assert property (p_ps_enter) else $error("power save entry wrong");

    property p_dummy_write;
        @(posedge clk) disable iff (!rstn)
        (ce && wr_ps && !reg_wdata[PS_BIT] && power_save_r && !indirect_mode)
            |=> (wake_pending_r && $stable(byte_cnt));
    endproperty
    a_dummy_write: assert property (p_dummy_write) else $error("woke without dummy write");

    property p_mc_write;
        @(posedge clk) disable iff (!rstn)
        (ce && wr_mc) |=> (byte_cnt == 8'h00 && line_cnt == 8'h00 && !display_enable_r);
    endproperty
    a_mc_write: assert property (p_mc_write) else $error("timing not reset by config write");

    property p_indirect_exit;
        @(posedge clk) disable iff (!rstn)
        (ce && wr_mc && indirect_mode) |=> (!power_save_r && !wake_pending_r);
    endproperty
    a_indirect_exit: assert property (p_indirect_exit) else $error("system set no wake");

    property p_segments;
        @(posedge clk) disable iff (!rstn)
        (ce && horizontal_char_size_r[3:0] == 4'h9)
            |=> (char_segments == 5'h02 && last_segment_mask == 8'hC0);
    endproperty
    a_segments: assert property (p_segments) else $error("segment split wrong");

    c_frame_wrap: cover property (@(posedge clk) disable iff (!rstn) ce && line_wrap);
    c_dummy_wake: cover property (@(posedge clk) disable iff (!rstn)
        ce && wake_pending_r ##1 !wake_pending_r && !power_save_r);
    c_ac_toggle: cover property (@(posedge clk) disable iff (!rstn)
        ce && !horizontal_char_size_r[HS_AC_SEL] && byte_wrap
        && ac_line_cnt_r == AC_LINES_LAST);
endmodule // lcsc_sys_config
`default_nettype wire

// *** tb/tb_top.sv ***
/*
 * tb_top: self-checking bench for lcsc_sys_config, reads checked through a queue.
 * Assumes lcsc_pkg and both design files are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lcsc_pkg::*;
    logic        clk, rstn, ce, reg_wr, reg_rd, indirect_mode, cmd_power_save, rd_d;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, last_segment_mask, f, m;
    logic [4:0]  char_height_px, char_segments;
    logic [8:0]  user_char_capacity;
    logic [3:0]  char_width_field, char_height_field;
    logic [14:0] line_address_range;
    logic        char_generator_select, one_bpp_only, font_row_shift, dual_panel;
    logic        h_active, line_start, frame_start, ac_drive, display_on, osc_stopped;
    logic [7:0]  expq[$];
    int          miscompares, samples_checked, i, px, sg;
    localparam logic [7:0] RV [10] = '{8'h10, 0, 0, 0, 0, 0, 0, 0, 8'h01, 0};
    localparam logic [7:0] MK [8]  = '{8'h3F, 8'h8F, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

    lcsc_sys_config u_dut (
        .clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .indirect_mode(indirect_mode), .cmd_power_save(cmd_power_save),
        .char_height_px(char_height_px), .char_generator_select(char_generator_select),
        .user_char_capacity(user_char_capacity), .one_bpp_only(one_bpp_only),
        .font_row_shift(font_row_shift), .dual_panel(dual_panel),
        .char_width_field(char_width_field), .char_height_field(char_height_field),
        .char_segments(char_segments), .last_segment_mask(last_segment_mask),
        .line_address_range(line_address_range), .h_active(h_active),
        .line_start(line_start), .frame_start(frame_start), .ac_drive(ac_drive),
        .display_on(display_on), .osc_stopped(osc_stopped));

    ////////////////////////////////////////////////////////////////////////////
    // 50 MHz clock, reset held six cycles
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask

    // read data lands one cycle after the strobe; oldest note is the match
    always @(posedge clk) begin
        if (rd_d)
            cmp(reg_rdata, expq.pop_front());
        rd_d <= reg_rd;
    end

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        expq.push_back(e);
        @(posedge clk);
        reg_rd   <= 1'b0;
    endtask

    // derived outputs lag their register by one more edge
    task automatic settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic pulse(input logic ind);
        @(posedge clk);
        indirect_mode  <= ind;
        cmd_power_save <= 1'b1;
        @(posedge clk);
        cmd_power_save <= 1'b0;
    endtask

    // cycles between two events: 0 line start, 1 frame start, 2 ac edge
    task automatic gap(input int sel, input logic [15:0] e);
        int n, k;
        logic ev, p;
        for (k = 0; k < 2; k++) begin
            n = 0;
            do begin
                p = ac_drive;
                @(posedge clk);
                n++;
                ev = (sel == 0) ? line_start : (sel == 1) ? frame_start : (ac_drive !== p);
            end while (!ev && n < 600);
        end
        cmp(16'(n), e);
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic wrap_up;
        $display("checks %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watchdog: whole run needs about four hundred cycles, allow about fifty times that
    initial begin
        #400000;
        miscompares++;
        wrap_up;
    end

    initial begin
        {rstn, reg_wr, reg_rd, indirect_mode, cmd_power_save} = '0;
        {reg_addr, reg_wdata} = '0;
        ce = 1'b1;
        void'($urandom(10));
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 10; i++) rd(16'h8000 + 16'(i), RV[i]);
        done("reset values");
        for (i = 0; i < 8; i++) begin
            f = 8'($urandom);
            wr(16'h8000 + 16'(i), f);
            rd(16'h8000 + 16'(i), f & MK[i]);
        end
        done("readback");
        for (i = 0; i < 2; i++) begin
            f = i ? 8'h2D : 8'h00;
            wr(ADDR_MEM_CFG, f);
            settle;
            cmp(char_height_px, f[2] ? 16 : 8);
            cmp(char_generator_select, f[0]);
            cmp(user_char_capacity, f[0] ? 256 : 64);
            cmp(one_bpp_only, f[0]);
            cmp(font_row_shift, !f[5]);
            cmp(dual_panel, f[3]);
        end
        done("char mode");
        for (i = 0; i < 6; i++) begin
            f = 8'($urandom);
            px = int'(f[3:0]) + 1;
            sg = (px + 7) / 8;
            m = 8'(16'hFF00 >> (px - 8 * (sg - 1)));
            wr(ADDR_HSIZE, f);
            wr(ADDR_VSIZE, f);
            settle;
            cmp(char_width_field, f[3:0]);
            cmp(char_segments, 16'(sg));
            cmp(last_segment_mask, m);
            cmp(char_height_field, f[3:0]);
        end
        // a write while the clock enable is low must leave the register alone
        @(posedge clk);
        ce <= 1'b0;
        wr(ADDR_VSIZE, ~f);
        ce <= 1'b1;
        rd(ADDR_VSIZE, f & MASK_VSIZE);
        done("char size");
        wr(ADDR_RANGE_HI, 8'h80);
        wr(ADDR_RANGE_LO, 8'h12);
        settle;
        cmp(line_address_range, 15'h7FFF);
        rd(ADDR_RANGE_HI, 8'h80);
        wr(ADDR_RANGE_HI, 8'h12);
        wr(ADDR_RANGE_LO, 8'h34);
        settle;
        cmp(line_address_range, 15'h1234);
        done("address range");
        // direct exit only completes after a dummy write, here to an unmapped place
        wr(ADDR_POWER, 8'h00);
        settle;
        cmp(osc_stopped, 1'b1);
        wr(16'h800A, 8'h55);
        settle;
        cmp(osc_stopped, 1'b0);
        rd(16'h800A, 8'h00);
        wr(ADDR_DISP_EN, 8'h01);
        settle;
        cmp(display_on, 1'b1);
        wr(ADDR_POWER, 8'h01);
        settle;
        cmp(osc_stopped, 1'b1);
        cmp(display_on, 1'b0);
        rd(ADDR_DISP_EN, 8'h00);
        done("direct power save");
        wr(ADDR_POWER, 8'h00);
        wr(ADDR_DISP_EN, 8'h01);
        pulse(1'b0);
        settle;
        cmp(osc_stopped, 1'b0);
        pulse(1'b1);
        settle;
        cmp(osc_stopped, 1'b1);
        wr(ADDR_MEM_CFG, 8'h10);
        settle;
        cmp(osc_stopped, 1'b0);
        cmp(display_on, 1'b0);
        @(posedge clk);
        indirect_mode <= 1'b0;
        done("indirect power save");
        wr(ADDR_TOTAL_ROW, 8'h03);
        wr(ADDR_ROW_BYTES, 8'h00);
        wr(ADDR_FRAME, 8'h01);
        wr(ADDR_HSIZE, 8'h80);
        // restart the counters so old random limits do not skew the first gaps
        wr(ADDR_MEM_CFG, 8'h18);
        wr(ADDR_DISP_EN, 8'h01);
        gap(0, 16'd4);
        // one visible byte in every four byte line
        px = 0;
        repeat (40) begin
            @(posedge clk);
            px += int'(h_active);
        end
        cmp(16'(px), 16'd10);
        gap(1, 16'd8);
        gap(2, 16'd8);
        wr(ADDR_HSIZE, 8'h00);
        gap(2, 16'd64);
        done("timing");
        wrap_up;
    end
endmodule // tb_top
`default_nettype wire
